// ==== pkg/tmr_regs.svh ====
// register offsets, field positions, reset values and prescaler taps
// for the 16-bit timer; included by every design file under src and by the bench
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// byte offsets on the register port
`define TMR_CTRL_A     4'h0
`define TMR_CTRL_B     4'h1
`define TMR_CNT_LO     4'h2
`define TMR_CNT_HI     4'h3
`define TMR_CMPA_LO    4'h4
`define TMR_CMPA_HI    4'h5
`define TMR_CMPB_LO    4'h6
`define TMR_CMPB_HI    4'h7
`define TMR_CAP_LO     4'h8
`define TMR_CAP_HI     4'h9
`define TMR_INT_STAT   4'ha
`define TMR_INT_CLR    4'hb
`define TMR_INT_EN     4'hc
`define TMR_PIN_DIR    4'hd

// field positions and writable masks
`define TMR_COMA_POS   6
`define TMR_WGML_POS   0
`define TMR_WGMH_POS   3
`define TMR_CS_POS     0
`define TMR_CTRL_A_MSK 8'hf3
`define TMR_CTRL_B_MSK 8'h1f
`define TMR_FLAG_OVF   0
`define TMR_FLAG_CMPA  1
`define TMR_FLAG_CMPB  2
`define TMR_FLAG_CAP   3

// reset values and counter landmarks
`define TMR_RST_BYTE   8'h00
`define TMR_RST_WORD   16'h0000
`define TMR_BOTTOM     16'h0000
`define TMR_MAX        16'hffff
`define TMR_TOP8       16'h00ff
`define TMR_TOP9       16'h01ff
`define TMR_TOP10      16'h03ff

// waveform mode codes
`define TMR_WGM_FAST8  4'h5
`define TMR_WGM_FAST9  4'h6
`define TMR_WGM_FAST10 4'h7
`define TMR_WGM_CTC_A  4'h4
`define TMR_WGM_CTC_I  4'hc
`define TMR_WGM_FAST_I 4'he
`define TMR_WGM_FAST_A 4'hf

// clock select codes and divider tap msbs (n = 8, 64, 256, 1024)
`define TMR_CS_DIV1    3'h1
`define TMR_CS_DIV8    3'h2
`define TMR_CS_DIV64   3'h3
`define TMR_CS_DIV256  3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_TAP8       2
`define TMR_TAP64      5
`define TMR_TAP256     7
`define TMR_TAP1024    9

`endif

// ==== pkg/tmr_pkg.sv ====
// types shared by the 16-bit timer modules
// assumes nothing beyond a systemverilog compiler
package tmr_pkg;

    typedef enum logic [1:0] {
        TMR_NORMAL = 2'b00,
        TMR_CTC    = 2'b01,
        TMR_FAST   = 2'b10
    } tmr_class_t;

endpackage

// ==== pkg/tmr_base_if.sv ====
// shared timebase carried from the timer core to its compare units
// assumes tmr_pkg is compiled first
`timescale 1ns/1ps
interface tmr_base_if;
    import tmr_pkg::*;

    logic        tick;
    logic [15:0] count;
    logic [15:0] top;
    logic        block;
    tmr_class_t  mode_class;

    modport timebase (output tick, count, top, block, mode_class);
    modport unit     (input  tick, count, top, block, mode_class);
endinterface

// ==== src/tmr_prescaler.sv ====
// clock prescaler: one-cycle timer tick every n clocks
// assumes a synchronous active-high reset on mclk
`timescale 1ns/1ps
`include "tmr_regs.svh"
module tmr_prescaler
    import tmr_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // clock select, zero stops the timer
    input  wire logic [2:0] clk_sel,
    // timer clock pulse
    output logic            tick
);
    logic [9:0] div_reg;

    always_ff @(posedge mclk)
    begin
        if (rst || clk_sel == 3'h0)
            div_reg <= 10'h000;
        else
            div_reg <= div_reg + 10'h001;
    end

    always_comb
    begin
        unique case (clk_sel)
            `TMR_CS_DIV1:    tick = 1'b1; // R7
            `TMR_CS_DIV8:    tick = &div_reg[`TMR_TAP8:0]; // R7
            `TMR_CS_DIV64:   tick = &div_reg[`TMR_TAP64:0]; // R7
            `TMR_CS_DIV256:  tick = &div_reg[`TMR_TAP256:0]; // R7
            `TMR_CS_DIV1024: tick = &div_reg[`TMR_TAP1024:0]; // R7
            default:         tick = 1'b0;
        endcase
    end
endmodule

// ==== src/tmr_compare.sv ====
// one compare unit: match detection and waveform generator
// assumes the timebase interface is driven by the timer core
`timescale 1ns/1ps
`include "tmr_regs.svh"
module tmr_compare
    import tmr_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // shared timebase
    tmr_base_if.unit         base,
    // channel setup
    input  wire logic [1:0]  out_mode,
    input  wire logic [15:0] compare,
    input  wire logic        toggle_ok,
    // match event and waveform
    output logic             match,
    output logic             wave,
    output logic             connected
);
    logic at_top;

    assign at_top = (base.count == base.top);
    assign match = base.tick && !base.block && base.count == compare; // R14

    always_ff @(posedge mclk)
    begin
        if (rst)
            wave <= 1'b0;
        else if (base.tick)
        begin
            unique case (base.mode_class)
                TMR_FAST:
                begin
                    if (out_mode[1] && at_top)
                        wave <= out_mode[0]; // R10 R11 R15
                    else if (out_mode[1] && match)
                        wave <= ~out_mode[0]; // R10 R11
                    else if (out_mode == 2'h1 && toggle_ok && match)
                        wave <= ~wave;
                end
                default:
                begin
                    if (match && out_mode == 2'h1)
                        wave <= ~wave; // R5
                    else if (match && out_mode[1])
                        wave <= out_mode[0];
                end
            endcase
        end
    end

    // toggle in fast pwm only where the channel allows it
    assign connected = out_mode[1] || (out_mode == 2'h1
                       && (base.mode_class != TMR_FAST || toggle_ok));
endmodule

// ==== src/tmr_top.sv ====
// 16-bit timer/counter with clear-on-match and fast pwm waveforms
// assumes a byte-wide register master on mclk and sync reset rst
//
// Summary of operation
// R1: in clear-on-match mode reaching top raises the compare-a flag or the capture flag, whichever register holds top.
// R2: in clear-on-match mode a write to the top register takes effect at once, with no double buffer.
// R3: a top written below the running count is missed; the count runs to 0xffff, wraps to 0x0000 and only then can match.
// R4: in waveform mode 15 compare value a defines top and is double buffered.
// R5: with output mode a set to 1 in clear-on-match mode, channel a inverts on every compare match.
// R6: the channel a waveform drives the pin only while its direction bit is 1.
// R7: toggle frequency is the clock over 2 times n times (1 plus compare value a), n being 1, 8, 64, 256 or 1024.
// R8: in clear-on-match mode the overflow flag is set in the timer clock where the count rolls from max to 0x0000.
// R9: fast pwm (modes 5, 6, 7, 14, 15) counts from bottom to top, then restarts at bottom.
// R10: fast pwm non-inverting output sets on compare match and clears at top.
// R11: fast pwm inverting output clears on compare match and sets at top.
// R12: software moves 16-bit values as an uninterrupted byte pair, low byte read first.
// R13: all 16-bit byte accesses go through one shared 8-bit high-byte latch.
// R14: a counter write blocks compare matches on the next timer clock for every unit.
// R15: in fast pwm a compare equal to top with the upper mode bit set only acts at top.
// R16: in clear-on-match mode the count returns to bottom on the timer clock after it matches top.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`include "tmr_regs.svh"
module tmr_top
    import tmr_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // compare output pins
    output logic            wave_out_a,
    output logic            wave_out_a_oe,
    output logic            wave_out_b,
    output logic            wave_out_b_oe,
    // interrupt
    output logic            irq
);
    logic [7:0]  ctrl_a_reg;
    logic [7:0]  ctrl_b_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] capture_value_reg;
    logic [7:0]  temp_reg;
    logic [3:0]  flags_reg;
    logic [3:0]  enable_reg;
    logic [1:0]  pin_dir_reg;
    logic        block_reg;
    logic [7:0]  rdata_reg;
    logic [3:0]  waveform_mode;
    logic [2:0]  clk_sel;
    logic        tick;
    tmr_class_t  mode_class;
    logic [15:0] top;
    logic        top_is_cap;
    logic        at_top;
    logic        cnt_write;
    logic [1:0]  toggle_ok;
    logic [3:0]  flag_set;
    logic [3:0]  flag_clr;
    logic [7:0]  rd_mux;
    logic [7:0]  rd_high;
    logic        rd_is_low;
    logic        wr_is_high;
    wire  [15:0] cmp_eff [2];
    wire  [15:0] cmp_buf [2];
    wire  [1:0]  out_mode [2];
    wire  [1:0]  match;
    wire  [1:0]  wave;
    wire  [1:0]  conn;

    tmr_base_if base ();

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    assign waveform_mode = {ctrl_b_reg[`TMR_WGMH_POS +: 2],
                            ctrl_a_reg[`TMR_WGML_POS +: 2]};
    assign clk_sel = ctrl_b_reg[`TMR_CS_POS +: 3];

    tmr_prescaler u_presc (
        .mclk    (mclk),
        .rst     (rst),
        .clk_sel (clk_sel),
        .tick    (tick)
    );

    // mode decode: class of operation and top source
    always_comb
    begin
        mode_class = TMR_NORMAL;
        top = `TMR_MAX;
        top_is_cap = 1'b0;
        unique case (waveform_mode)
            `TMR_WGM_CTC_A:
            begin
                mode_class = TMR_CTC;
                top = cmp_eff[0]; // R1
            end
            `TMR_WGM_CTC_I:
            begin
                mode_class = TMR_CTC;
                top = capture_value_reg; // R1 R2
                top_is_cap = 1'b1;
            end
            `TMR_WGM_FAST8:
            begin
                mode_class = TMR_FAST;
                top = `TMR_TOP8;
            end
            `TMR_WGM_FAST9:
            begin
                mode_class = TMR_FAST;
                top = `TMR_TOP9;
            end
            `TMR_WGM_FAST10:
            begin
                mode_class = TMR_FAST;
                top = `TMR_TOP10;
            end
            `TMR_WGM_FAST_I:
            begin
                mode_class = TMR_FAST;
                top = capture_value_reg;
                top_is_cap = 1'b1;
            end
            `TMR_WGM_FAST_A:
            begin
                mode_class = TMR_FAST;
                top = cmp_eff[0]; // R4
            end
            default:
            begin
                mode_class = TMR_NORMAL;
            end
        endcase
    end

    assign at_top = (count_reg == top);
    assign toggle_ok[0] = (waveform_mode == `TMR_WGM_FAST_I)
                          || (waveform_mode == `TMR_WGM_FAST_A);
    assign toggle_ok[1] = 1'b0;

    assign base.tick = tick;
    assign base.count = count_reg;
    assign base.top = top;
    assign base.block = block_reg;
    assign base.mode_class = mode_class;

    // compare channels a and b
    for (genvar i = 0; i < 2; i++)
    begin : g_chan
        localparam logic [3:0] LO_ADDR = 4'(`TMR_CMPA_LO + 2 * i);
        logic [15:0] buf_reg;
        logic [15:0] act_reg;

        always_ff @(posedge mclk)
        begin
            if (rst)
                buf_reg <= `TMR_RST_WORD;
            else if (reg_wr && reg_addr == LO_ADDR)
                buf_reg <= {temp_reg, reg_wdata}; // R13
        end

        always_ff @(posedge mclk)
        begin
            if (rst)
                act_reg <= `TMR_RST_WORD;
            else if (mode_class != TMR_FAST)
                act_reg <= buf_reg;
            else if (tick && at_top)
                act_reg <= buf_reg; // R4
        end

        assign cmp_buf[i] = buf_reg;
        assign cmp_eff[i] = (mode_class == TMR_FAST) ? act_reg : buf_reg; // R2
        assign out_mode[i] = ctrl_a_reg[`TMR_COMA_POS - 2 * i +: 2];

        tmr_compare u_cmp (
            .mclk      (mclk),
            .rst       (rst),
            .base      (base),
            .out_mode  (out_mode[i]),
            .compare   (cmp_eff[i]),
            .toggle_ok (toggle_ok[i]),
            .match     (match[i]),
            .wave      (wave[i]),
            .connected (conn[i])
        );
    end

    // counter
    assign cnt_write = reg_wr && reg_addr == `TMR_CNT_LO;

    always_comb
    begin
        if (cnt_write)
            count_next = {temp_reg, reg_wdata}; // R13
        else if (tick && mode_class != TMR_NORMAL && at_top)
            count_next = `TMR_BOTTOM; // R9 R16
        else if (tick)
            count_next = count_reg + 16'h0001; // R3
        else
            count_next = count_reg;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            count_reg <= `TMR_RST_WORD;
        else
            count_reg <= count_next;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            block_reg <= 1'b0;
        else if (cnt_write)
            block_reg <= 1'b1; // R14
        else if (tick)
            block_reg <= 1'b0;
    end

    // control registers
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl_a_reg <= `TMR_RST_BYTE;
            ctrl_b_reg <= `TMR_RST_BYTE;
            enable_reg <= 4'h0;
            pin_dir_reg <= 2'h0;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `TMR_CTRL_A: ctrl_a_reg <= reg_wdata & `TMR_CTRL_A_MSK;
                `TMR_CTRL_B: ctrl_b_reg <= reg_wdata & `TMR_CTRL_B_MSK;
                `TMR_INT_EN: enable_reg <= reg_wdata[3:0];
                `TMR_PIN_DIR: pin_dir_reg <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            capture_value_reg <= `TMR_RST_WORD;
        else if (reg_wr && reg_addr == `TMR_CAP_LO)
            capture_value_reg <= {temp_reg, reg_wdata}; // R2 R13
    end

    // shared high-byte latch
    assign wr_is_high = reg_addr[0] && reg_addr >= `TMR_CNT_HI
                        && reg_addr <= `TMR_CAP_HI;

    always_ff @(posedge mclk)
    begin
        if (rst)
            temp_reg <= `TMR_RST_BYTE;
        else if (reg_wr && wr_is_high)
            temp_reg <= reg_wdata; // R13
        else if (reg_rd && rd_is_low)
            temp_reg <= rd_high; // R13
    end

    // interrupt flags: set wins over clear
    assign flag_set[`TMR_FLAG_OVF] = tick && !cnt_write
        && ((mode_class == TMR_FAST) ? at_top : count_reg == `TMR_MAX); // R8
    assign flag_set[`TMR_FLAG_CMPA] = match[0]; // R1
    assign flag_set[`TMR_FLAG_CMPB] = match[1];
    assign flag_set[`TMR_FLAG_CAP] = tick && at_top && top_is_cap; // R1
    assign flag_clr = (reg_wr && reg_addr == `TMR_INT_CLR)
                      ? reg_wdata[3:0] : 4'h0;

    always_ff @(posedge mclk)
    begin
        if (rst)
            flags_reg <= 4'h0;
        else
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
    end

    assign irq = |(flags_reg & enable_reg);

    // read path
    always_comb
    begin
        rd_mux = 8'h00;
        rd_high = 8'h00;
        rd_is_low = 1'b0;
        unique case (reg_addr)
            `TMR_CTRL_A: rd_mux = ctrl_a_reg;
            `TMR_CTRL_B: rd_mux = ctrl_b_reg;
            `TMR_CNT_LO:
            begin
                rd_mux = count_reg[7:0];
                rd_high = count_reg[15:8];
                rd_is_low = 1'b1;
            end
            `TMR_CMPA_LO:
            begin
                rd_mux = cmp_buf[0][7:0];
                rd_high = cmp_buf[0][15:8];
                rd_is_low = 1'b1;
            end
            `TMR_CMPB_LO:
            begin
                rd_mux = cmp_buf[1][7:0];
                rd_high = cmp_buf[1][15:8];
                rd_is_low = 1'b1;
            end
            `TMR_CAP_LO:
            begin
                rd_mux = capture_value_reg[7:0];
                rd_high = capture_value_reg[15:8];
                rd_is_low = 1'b1;
            end
            `TMR_CNT_HI, `TMR_CMPA_HI, `TMR_CMPB_HI, `TMR_CAP_HI:
                rd_mux = temp_reg; // R13
            `TMR_INT_STAT: rd_mux = {4'h0, flags_reg};
            `TMR_INT_EN: rd_mux = {4'h0, enable_reg};
            `TMR_PIN_DIR: rd_mux = {6'h00, pin_dir_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            rdata_reg <= 8'h00;
        else if (reg_rd)
            rdata_reg <= rd_mux;
        else
            rdata_reg <= 8'h00;
    end

    assign reg_rdata = rdata_reg;

    // pins
    assign wave_out_a = conn[0] & wave[0];
    assign wave_out_b = conn[1] & wave[1];
    assign wave_out_a_oe = pin_dir_reg[0]; // R6
    assign wave_out_b_oe = pin_dir_reg[1];

    // checks
    a_ctc_top_flag: assert property ( // R1
        (mode_class == TMR_CTC && !top_is_cap && tick && !block_reg
         && at_top) |=> flags_reg[`TMR_FLAG_CMPA])
        else $error("compare a flag not raised at top");

    a_ctc_no_buffer: assert property ( // R2
        (mode_class == TMR_CTC && reg_wr && reg_addr == `TMR_CMPA_LO)
        |=> cmp_eff[0] == {$past(temp_reg), $past(reg_wdata)})
        else $error("top write not taken at once");

    a_ctc_miss_wrap: assert property ( // R3
        (mode_class == TMR_CTC && tick && !cnt_write && count_reg > top)
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("count above top did not keep counting");

    a_fast_top_held: assert property ( // R4
        (waveform_mode == `TMR_WGM_FAST_A && reg_wr
         && reg_addr == `TMR_CMPA_LO && !(tick && at_top))
        |=> $stable(top))
        else $error("buffered top changed before top");

    a_ctc_toggle: assert property ( // R5
        (mode_class == TMR_CTC && out_mode[0] == 2'h1 && match[0])
        |=> wave[0] != $past(wave[0]))
        else $error("channel a did not toggle on match");

    a_pin_enable: assert property ( // R6
        (reg_wr && reg_addr == `TMR_PIN_DIR)
        |=> wave_out_a_oe == $past(reg_wdata[0]))
        else $error("pin enable does not follow direction bit");

    a_ovf_roll: assert property ( // R8
        (mode_class != TMR_FAST && tick && !cnt_write
         && count_reg == `TMR_MAX)
        |=> count_reg == `TMR_BOTTOM && flags_reg[`TMR_FLAG_OVF])
        else $error("overflow flag missing at rollover");

    a_fast_restart: assert property ( // R9
        (mode_class == TMR_FAST && tick && at_top && !cnt_write)
        |=> count_reg == `TMR_BOTTOM ##1 !at_top || top == `TMR_BOTTOM)
        else $error("fast pwm did not restart from bottom");

    a_fast_noninv: assert property ( // R10
        (mode_class == TMR_FAST && out_mode[0] == 2'h2 && tick && at_top)
        |=> !wave[0])
        else $error("non-inverting output not cleared at top");

    a_fast_inv: assert property ( // R11
        (mode_class == TMR_FAST && out_mode[0] == 2'h3 && match[0]
         && !at_top) |=> !wave[0])
        else $error("inverting output not cleared on match");

    a_temp_latch: assert property ( // R13
        (reg_rd && reg_addr == `TMR_CNT_LO)
        ##1 (reg_rd && reg_addr == `TMR_CNT_HI)
        |=> reg_rdata == $past(temp_reg))
        else $error("high byte not taken from latch");

    a_write_block: assert property ( // R14
        cnt_write |=> match == 2'h0)
        else $error("match after counter write");

    a_ctc_clear: assert property ( // R16
        (mode_class == TMR_CTC && tick && at_top && !cnt_write)
        |=> count_reg == `TMR_BOTTOM)
        else $error("clear-on-match count not cleared");
endmodule

// ==== tb/tmr_pin_model.sv ====
// port pin seen by the outside world for one compare channel
// assumes wave and oe come from the timer top on mclk
`timescale 1ns/1ps
module tmr_pin_model
(
    // clock
    input  wire logic mclk,
    // pin driver side
    input  wire logic wave,
    input  wire logic oe,
    // resolved pad level
    output logic      pad
);
    logic last_reg = 1'b0;

    always_ff @(posedge mclk)
    begin
        if (oe)
            last_reg <= wave;
    end

    // released pad shows the inverse of the last driven value
    assign pad = oe ? wave : ~last_reg;
endmodule

// ==== tb/timer16_ctc_fast_pwm_tb.sv ====
// self-checking bench for the 16-bit timer top
// assumes tmr_pkg, tmr_base_if and the design sources are compiled first
`timescale 1ns/1ps
`include "tmr_regs.svh"
module timer16_ctc_fast_pwm_tb;
    import tmr_pkg::*;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
    logic        irq, pad_a;
    logic [7:0]  d;
    logic [15:0] v, got;
    logic [3:0]  offs [6] = '{`TMR_CTRL_A, `TMR_CTRL_B, `TMR_INT_STAT,
                              `TMR_INT_EN, `TMR_PIN_DIR, 4'he};
    int          n_mismatch = 0;
    int          compares = 0;
    int          cyc = 0;
    int          hi, lo, n, c;

    always #10 mclk = ~mclk;

    tmr_top dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .wave_out_a(wave_out_a),
        .wave_out_a_oe(wave_out_a_oe), .wave_out_b(wave_out_b),
        .wave_out_b_oe(wave_out_b_oe), .irq(irq));

    tmr_pin_model pin_a (.mclk(mclk), .wave(wave_out_a),
        .oe(wave_out_a_oe), .pad(pad_a));

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic step();
        @(posedge mclk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] w);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= w;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] r);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        r = reg_rdata;
    endtask

    // high byte first into the shared latch, then low byte
    task automatic wr16(input logic [3:0] a, input logic [15:0] w);
        wr(a + 4'h1, w[15:8]);
        wr(a, w[7:0]);
    endtask

    // low byte first, high byte from the latch
    task automatic rd16(input logic [3:0] a, output logic [15:0] r);
        rd(a, r[7:0]);
        rd(a + 4'h1, r[15:8]);
    endtask

    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] s);
        compares++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask

    // one full high and low phase of channel a, bounded
    task automatic meas(output int h, output int l);
        int k;
        k = 0;
        h = 0;
        l = 0;
        while (wave_out_a !== 1'b0 && k < 4000) begin step(); k++; end
        while (wave_out_a !== 1'b1 && k < 4000) begin step(); k++; end
        while (wave_out_a === 1'b1 && k < 4000) begin step(); h++; k++; end
        while (wave_out_a === 1'b0 && k < 4000) begin step(); l++; k++; end
    endtask

    initial
    begin
        void'($urandom(2));
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        foreach (offs[i])
        begin
            rd(offs[i], d);
            chk("reset read", 16'h0000, {8'h00, d});
        end
        chk("pin enable", 16'h0000, 16'(wave_out_a_oe));
        $display("test reset done");
        // compare-a high byte fills the latch used by the counter low write
        v = 16'($urandom());
        wr(`TMR_CMPA_HI, v[15:8]);
        wr(`TMR_CNT_LO, v[7:0]);
        rd16(`TMR_CNT_LO, got);
        chk("counter", v, got);
        $display("test latch done");
        for (int i = 0; i < 3; i++)
        begin
            c = $urandom_range(3);
            n = 1 << (3 * i);
            wr(`TMR_CTRL_B, 8'h00);
            wr16(`TMR_CNT_LO, 16'h0000);
            wr16(`TMR_CMPA_LO, 16'(c));
            wr(`TMR_CTRL_A, 8'h40);
            wr(`TMR_PIN_DIR, 8'h01);
            wr(`TMR_CTRL_B, 8'h08 | 8'(i + 1));
            meas(hi, lo);
            chk("toggle high", 16'(n * (1 + c)), 16'(hi));
            chk("toggle low", 16'(n * (1 + c)), 16'(lo));
            chk("pad", 16'(wave_out_a), 16'(pad_a));
        end
        rd(`TMR_INT_STAT, d);
        chk("match flag", 16'h0001, 16'(d[1]));
        chk("irq masked", 16'h0000, 16'(irq));
        wr(`TMR_INT_EN, 8'h02);
        step();
        chk("irq", 16'h0001, 16'(irq));
        wr(`TMR_CTRL_B, 8'h00);
        wr(`TMR_INT_CLR, 8'h0f);
        step();
        chk("irq cleared", 16'h0000, 16'(irq));
        $display("test toggle done");
        wr16(`TMR_CNT_LO, 16'hfff0);
        wr16(`TMR_CMPA_LO, 16'h0005);
        wr(`TMR_INT_CLR, 8'h0f);
        wr(`TMR_CTRL_B, 8'h09);
        repeat (8) step();
        rd(`TMR_INT_STAT, d);
        chk("no early match", 16'h0000, 16'(d & 8'h0b));
        repeat (30) step();
        rd(`TMR_INT_STAT, d);
        chk("wrap flags", 16'h0003, 16'(d & 8'h0b));
        // raise top above the running count, then move top to capture
        wr16(`TMR_CMPA_LO, 16'h0008);
        wr16(`TMR_CAP_LO, 16'h0009);
        wr(`TMR_INT_CLR, 8'h0f);
        wr(`TMR_CTRL_B, 8'h19);
        repeat (20) step();
        rd(`TMR_INT_STAT, d);
        chk("capture top flag", 16'h0008, 16'(d & 8'h09));
        $display("test wrap done");
        for (int m = 2; m < 4; m++)
        begin
            wr(`TMR_CTRL_B, 8'h00);
            wr16(`TMR_CAP_LO, 16'h0009);
            wr16(`TMR_CMPA_LO, 16'h0003);
            wr16(`TMR_CMPB_LO, 16'h0006);
            wr16(`TMR_CNT_LO, 16'h0000);
            wr(`TMR_CTRL_A, 8'(m << 6) | 8'(m << 4) | 8'h02);
            wr(`TMR_CTRL_B, 8'h19);
            meas(hi, lo);
            meas(hi, lo);
            chk("pwm high", 16'(m == 2 ? 6 : 4), 16'(hi));
            chk("pwm low", 16'(m == 2 ? 4 : 6), 16'(lo));
            chk("chan b", 16'(m == 3), 16'(wave_out_b));
        end
        // mode 15: compare a is top, channel a toggles once a period
        wr(`TMR_CTRL_A, 8'h43);
        wr16(`TMR_CMPA_LO, 16'h0007);
        meas(hi, lo);
        meas(hi, lo);
        chk("top a period", 16'h0008, 16'(hi));
        $display("test fast pwm done");
        wr(`TMR_PIN_DIR, 8'h02);
        step();
        chk("pin released", 16'h0000, 16'(wave_out_a_oe));
        chk("pin b enable", 16'h0001, 16'(wave_out_b_oe));
        $display("test pin done");
        summarize();
    end
endmodule
